// ==== design/otm_pkg.sv ====
// constants, slot modes and the frame-alignment helper of the octet multiplexer
// assumes one 20 MHz clock shared by both ends of the link
package otm_pkg;

  localparam int CLK_NS = 50;
  localparam int FRAME_NS = 125000;
  localparam int FRAME_CYC = FRAME_NS / CLK_NS;
  localparam int CYC_W = 12;
  localparam int OCT_W = 8;
  localparam int MF_LEN = 20;
  localparam logic [MF_LEN-1:0] FA_PATTERN = 20'hB3C5A;
  localparam int SIG_DIV = 10;
  localparam int SIG_LEN = 20;
  localparam int SIG_CH = 18;
  localparam logic [4:0] SIG_SYNC_IDX = 5'h00;
  localparam logic [4:0] SIG_ALARM_IDX = 5'h0A;
  localparam logic ALARM_ON = 1'b0;
  localparam logic ALARM_OFF = 1'b1;
  localparam logic E48_FILL = 1'b1;
  localparam logic [OCT_W-1:0] OCT_FILL = 8'h00;
  localparam int OOF_MISS = 3;
  localparam int IN_HITS = 4;

  typedef enum logic [2:0] {
    S_UNUSED = 3'h0,
    S_X50 = 3'h1,
    S_E48 = 3'h2,
    S_E56 = 3'h3,
    S_OCT = 3'h4,
    S_VOICE = 3'h5,
    S_SIG = 3'h6
  } otm_slot_t;

  typedef struct packed {
    logic [4:0] mf;
    logic [2:0] hits;
    logic oof;
  } otm_align_t;

  localparam otm_align_t ALIGN_RST = '{mf: 5'h00, hits: 3'h0, oof: 1'b1};

  // one frame-alignment bit into the hunt / in-frame tracker
  function automatic otm_align_t otm_align(input otm_align_t cur, input logic fbit);
    otm_align_t n;
    logic match;
    n = cur;
    match = (fbit == FA_PATTERN[cur.mf]);
    n.mf = (cur.mf == 5'(MF_LEN - 1)) ? 5'h00 : cur.mf + 5'h01;
    if (cur.oof) begin
      if (!match) begin
        n.hits = 3'h0;
        n.mf = cur.mf;
      end else if (cur.hits == 3'(IN_HITS - 1)) begin
        n.hits = 3'h0;
        n.oof = 1'b0;
      end else begin
        n.hits = cur.hits + 3'h1;
      end
    end else begin
      if (match) begin
        n.hits = 3'h0;
      end else if (cur.hits == 3'(OOF_MISS - 1)) begin
        n.hits = 3'h0;
        n.oof = 1'b1;
      end else begin
        n.hits = cur.hits + 3'h1;
      end
    end
    return n;
  endfunction

  // signalling multiframe position to channel number
  function automatic logic [4:0] otm_sig_ch(input logic [4:0] idx);
    return (idx < SIG_ALARM_IDX) ? idx - 5'h01 : idx - 5'h02;
  endfunction

endpackage

// ==== design/otm_link_if.sv ====
// octet link between the multiplexer and its peer, one slot per clock
// assumes both ends share clock_i; the bench joins the two modports
`timescale 1ns/10ps
interface otm_link_if #(
  parameter int NUM_SLOTS = 8
);
  localparam int SW = (NUM_SLOTS > 1) ? $clog2(NUM_SLOTS) : 1;
  logic [7:0] fwd_octet;
  logic [SW-1:0] fwd_slot;
  logic fwd_sof;
  logic fwd_valid;
  logic fwd_used;
  logic [7:0] rev_octet;
  logic rev_valid;
  modport mux (
    output fwd_octet, fwd_slot, fwd_sof, fwd_valid, fwd_used,
    input rev_octet, rev_valid
  );
  modport peer (
    input fwd_octet, fwd_slot, fwd_sof, fwd_valid, fwd_used,
    output rev_octet, rev_valid
  );
endinterface

// ==== design/otm_fifo.sv ====
// flip-flop FIFO with valid/ready on both sides and registered flags
// assumes a synchronous active-high reset
`timescale 1ns/10ps
module otm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("otm_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] nxt_mem [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic ready_ff, nxt_ready, valid_ff, nxt_valid;
  logic push, pop;

  always_comb begin
    push = in_valid_i & ready_ff;
    pop = out_ready_i & valid_ff;
    nxt_mem = mem_ff;
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    if (push) begin
      nxt_mem[wr_ff] = in_data_i;
      nxt_wr = wr_ff + 1'b1;
    end
    if (pop) begin
      nxt_rd = rd_ff + 1'b1;
    end
    nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    nxt_ready = (nxt_cnt != (AW+1)'(DEPTH));
    nxt_valid = (nxt_cnt != '0);
  end

  always_ff @(posedge clock_i) begin
    mem_ff <= nxt_mem;
    if (reset_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      ready_ff <= 1'b0;
      valid_ff <= 1'b0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
      ready_ff <= nxt_ready;
      valid_ff <= nxt_valid;
    end
  end

  assign in_ready_o = ready_ff;
  assign out_valid_o = valid_ff;
  assign out_data_o = mem_ff[rd_ff];
endmodule // otm_fifo

// ==== design/otm_mux.sv ====
// transmitting multiplexer: builds the 125 us user-channel frame slot by slot
// assumes the peer returns one alignment octet per frame on the reverse path
`timescale 1ns/10ps
// Operation
// - sub-64k signals packed into one 64k slot
// - each 64k stream fills exactly one slot
// - frame of octet slots every 125 us
// - unused slots and positions are don't-care
// - slow async data rides the 2.4k group
// - n x 2.4k sync in 6+2 envelope
// - eighth envelope bit carries status flag
// - X.50 20-frame alignment pattern, receiver aligns
// - 14.4k and 19.2k split into sub-streams
// - path alarm reports out-of-frame on link
// - path alarm 1 means none, 0 alarm
// - 48k: bit 1 free, bits 2-7 data
// - 56k: seven data bits plus status
// - n x 64k octets kept in order
// - n x 8k uses contiguous bits in slot
// - 32k halves, 16k aligned bit pairs
// - signalling sampled at 0.8 kHz into multiframe
// - signalling bit 1 alternates per multiframe
// - bit 11 alarm, others carry channel signalling
// - voice-to-signalling mapping free, rates mix
module otm_mux #(
  parameter int NUM_SLOTS = 8,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire otm_pkg::otm_slot_t [NUM_SLOTS-1:0] slot_type_i,
  input wire logic [NUM_SLOTS-1:0][7:0] slot_data_i,
  input wire logic [NUM_SLOTS-1:0] slot_stat_i,
  input wire logic [NUM_SLOTS-1:0][7:0] voice_mask_i,
  input wire logic [otm_pkg::SIG_CH-1:0] sig_i,
  input wire logic oct_valid_i,
  input wire logic [otm_pkg::OCT_W-1:0] oct_data_i,
  output logic oct_ready_o,
  output logic oof_o,
  output logic far_alarm_o,
  otm_link_if.mux link
);
  import otm_pkg::*;

  localparam int SW = (NUM_SLOTS > 1) ? $clog2(NUM_SLOTS) : 1;

  if (NUM_SLOTS < 1 || NUM_SLOTS > FRAME_CYC) begin : g_bad_slots
    $error("otm_mux slot count must fit one frame");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [CYC_W-1:0] cyc_ff, nxt_cyc;
  logic [4:0] mf_ff, nxt_mf;
  logic [3:0] sdiv_ff, nxt_sdiv;
  logic [4:0] sidx_ff, nxt_sidx;
  logic sync_ff, nxt_sync;
  logic sbit_ff, nxt_sbit;
  logic [7:0] oct_ff, nxt_oct;
  logic [SW-1:0] slot_ff, nxt_slot;
  logic sof_ff, nxt_sof;
  logic val_ff, nxt_val;
  logic used_ff, nxt_used;
  otm_align_t al_ff, nxt_al;
  logic far_ff, nxt_far;

  logic frame_end;
  logic in_slot;
  logic [SW-1:0] cur;
  logic [7:0] d;
  logic pop;
  logic q_valid;
  logic [OCT_W-1:0] q_data;

  ////////////////////////////////////////////////////////////////////////////
  // octet buffer for n x 64k data

  otm_fifo #(
    .WIDTH(OCT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .in_valid_i(oct_valid_i),
    .in_data_i(oct_data_i),
    .in_ready_o(oct_ready_o),
    .out_valid_o(q_valid),
    .out_data_o(q_data),
    .out_ready_i(pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // frame timing, multiframe counters and signalling sampler

  always_comb begin
    frame_end = (cyc_ff == CYC_W'(FRAME_CYC - 1));
    nxt_cyc = frame_end ? '0 : cyc_ff + 1'b1;
    nxt_mf = mf_ff;
    nxt_sdiv = sdiv_ff;
    nxt_sidx = sidx_ff;
    nxt_sync = sync_ff;
    nxt_sbit = sbit_ff;
    if (frame_end) begin
      nxt_mf = (mf_ff == 5'(MF_LEN - 1)) ? 5'h00 : mf_ff + 5'h01;
      if (sdiv_ff == 4'(SIG_DIV - 1)) begin
        // one signalling bit per 1.25 ms
        nxt_sdiv = 4'h0;
        nxt_sidx = (sidx_ff == 5'(SIG_LEN - 1)) ? 5'h00 : sidx_ff + 5'h01;
        if (nxt_sidx == SIG_SYNC_IDX) begin
          nxt_sync = ~sync_ff;
          nxt_sbit = ~sync_ff;
        end else if (nxt_sidx == SIG_ALARM_IDX) begin
          nxt_sbit = al_ff.oof ? ALARM_ON : ALARM_OFF;
        end else begin
          nxt_sbit = sig_i[otm_sig_ch(nxt_sidx)];
        end
      end else begin
        nxt_sdiv = sdiv_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      cyc_ff <= '0;
      mf_ff <= 5'h00;
      sdiv_ff <= 4'h0;
      sidx_ff <= 5'h00;
      sync_ff <= 1'b0;
      sbit_ff <= 1'b0;
    end else begin
      cyc_ff <= nxt_cyc;
      mf_ff <= nxt_mf;
      sdiv_ff <= nxt_sdiv;
      sidx_ff <= nxt_sidx;
      sync_ff <= nxt_sync;
      sbit_ff <= nxt_sbit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slot builder: bit 1 of a slot is octet bit 7, bit 8 is octet bit 0

  always_comb begin
    in_slot = (cyc_ff < CYC_W'(NUM_SLOTS));
    cur = cyc_ff[SW-1:0];
    d = in_slot ? slot_data_i[cur] : 8'h00;
    pop = 1'b0;
    nxt_val = in_slot;
    nxt_sof = (cyc_ff == '0);
    nxt_slot = cur;
    nxt_used = 1'b0;
    nxt_oct = OCT_FILL;
    if (in_slot) begin
      nxt_used = 1'b1;
      unique case (slot_type_i[cur])
        S_UNUSED: begin
          nxt_used = 1'b0;
        end
        S_X50: begin
          // 2.4k group: async, split 14.4k/19.2k and n x 2.4k each own an envelope
          nxt_oct = {FA_PATTERN[mf_ff], d[5:0], slot_stat_i[cur]};
        end
        S_E48: begin
          nxt_oct = {E48_FILL, d[5:0], slot_stat_i[cur]};
        end
        S_E56: begin
          nxt_oct = {d[6:0], slot_stat_i[cur]};
        end
        S_OCT: begin
          // octets leave the buffer in arrival order, one per octet slot
          nxt_used = q_valid;
          pop = q_valid;
          nxt_oct = q_valid ? q_data : OCT_FILL;
        end
        S_VOICE: begin
          nxt_oct = d & voice_mask_i[cur];
        end
        S_SIG: begin
          nxt_oct = {sbit_ff, 7'h00};
        end
        default: begin
          nxt_used = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      oct_ff <= OCT_FILL;
      slot_ff <= '0;
      sof_ff <= 1'b0;
      val_ff <= 1'b0;
      used_ff <= 1'b0;
    end else begin
      oct_ff <= nxt_oct;
      slot_ff <= nxt_slot;
      sof_ff <= nxt_sof;
      val_ff <= nxt_val;
      used_ff <= nxt_used;
    end
  end

  assign link.fwd_octet = oct_ff;
  assign link.fwd_slot = slot_ff;
  assign link.fwd_sof = sof_ff;
  assign link.fwd_valid = val_ff;
  assign link.fwd_used = used_ff;

  ////////////////////////////////////////////////////////////////////////////
  // reverse path: alignment tracker and far-end alarm

  always_comb begin
    nxt_al = al_ff;
    nxt_far = far_ff;
    if (link.rev_valid) begin
      nxt_al = otm_align(al_ff, link.rev_octet[7]);
      nxt_far = (link.rev_octet[0] == ALARM_ON);
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      al_ff <= ALIGN_RST;
      far_ff <= 1'b0;
    end else begin
      al_ff <= nxt_al;
      far_ff <= nxt_far;
    end
  end

  assign oof_o = al_ff.oof;
  assign far_alarm_o = far_ff;
endmodule // otm_mux

// ==== design/otm_peer.sv ====
// receiving peer multiplexer: aligns, unpacks slots, returns alignment and alarm
// assumes the same slot plan as the transmitting end
`timescale 1ns/10ps
module otm_peer #(
  parameter int NUM_SLOTS = 8
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire otm_pkg::otm_slot_t [NUM_SLOTS-1:0] slot_type_i,
  input wire logic [NUM_SLOTS-1:0][7:0] voice_mask_i,
  otm_link_if.peer link,
  output logic [NUM_SLOTS-1:0][7:0] rx_data_o,
  output logic [NUM_SLOTS-1:0] rx_stat_o,
  output logic oct_valid_o,
  output logic [otm_pkg::OCT_W-1:0] oct_data_o,
  output logic [otm_pkg::SIG_CH-1:0] sig_o,
  output logic oof_o,
  output logic far_alarm_o
);
  import otm_pkg::*;

  if (NUM_SLOTS < 1 || NUM_SLOTS > FRAME_CYC) begin : g_bad_slots
    $error("otm_peer slot count must fit one frame");
  end

  logic [NUM_SLOTS-1:0][7:0] data_ff, nxt_data;
  logic [NUM_SLOTS-1:0] stat_ff, nxt_stat;
  logic ov_ff, nxt_ov;
  logic [OCT_W-1:0] od_ff, nxt_od;
  logic [SIG_CH-1:0] sig_ff, nxt_sig;
  otm_align_t al_ff, nxt_al;
  logic far_ff, nxt_far;
  logic fdone_ff, nxt_fdone, sdone_ff, nxt_sdone;
  logic [3:0] sdiv_ff, nxt_sdiv;
  logic [4:0] sidx_ff, nxt_sidx;
  logic sync_ff, nxt_sync;
  logic [7:0] rev_ff, nxt_rev;
  logic rval_ff, nxt_rval;
  logic fdone, sdone;
  logic [7:0] o;

  ////////////////////////////////////////////////////////////////////////////
  // slot unpacking

  always_comb begin
    nxt_data = data_ff;
    nxt_stat = stat_ff;
    nxt_ov = 1'b0;
    nxt_od = od_ff;
    nxt_sig = sig_ff;
    nxt_al = al_ff;
    nxt_far = far_ff;
    nxt_sdiv = sdiv_ff;
    nxt_sidx = sidx_ff;
    nxt_sync = sync_ff;
    nxt_rev = rev_ff;
    nxt_rval = link.fwd_sof;
    fdone = link.fwd_sof ? 1'b0 : fdone_ff;
    sdone = link.fwd_sof ? 1'b0 : sdone_ff;
    nxt_fdone = fdone;
    nxt_sdone = sdone;
    o = link.fwd_octet;
    if (link.fwd_sof) begin
      // one return octet per frame: own alignment bit and path alarm
      nxt_rev = {FA_PATTERN[al_ff.mf], 6'h00, al_ff.oof ? ALARM_ON : ALARM_OFF};
    end
    if (link.fwd_valid) begin
      unique case (slot_type_i[link.fwd_slot])
        S_UNUSED: begin
        end
        S_X50: begin
          if (!fdone) begin
            nxt_al = otm_align(al_ff, o[7]);
            nxt_fdone = 1'b1;
          end
          nxt_data[link.fwd_slot] = {2'b00, o[6:1]};
          nxt_stat[link.fwd_slot] = o[0];
        end
        S_E48: begin
          nxt_data[link.fwd_slot] = {2'b00, o[6:1]};
          nxt_stat[link.fwd_slot] = o[0];
        end
        S_E56: begin
          nxt_data[link.fwd_slot] = {1'b0, o[7:1]};
          nxt_stat[link.fwd_slot] = o[0];
        end
        S_OCT: begin
          nxt_ov = link.fwd_used;
          nxt_od = link.fwd_used ? o : od_ff;
        end
        S_VOICE: begin
          nxt_data[link.fwd_slot] = o & voice_mask_i[link.fwd_slot];
        end
        S_SIG: begin
          if (!sdone) begin
            nxt_sdone = 1'b1;
            nxt_sdiv = (sdiv_ff == 4'(SIG_DIV - 1)) ? 4'h0 : sdiv_ff + 4'h1;
            if (sdiv_ff == 4'h0) begin
              nxt_sidx = (sidx_ff == 5'(SIG_LEN - 1)) ? 5'h00 : sidx_ff + 5'h01;
              if (sidx_ff == SIG_SYNC_IDX) begin
                // no alternation: hold position to slip one bit
                if (o[7] == sync_ff) begin
                  nxt_sidx = sidx_ff;
                end
                nxt_sync = o[7];
              end else if (sidx_ff == SIG_ALARM_IDX) begin
                nxt_far = (o[7] == ALARM_ON);
              end else begin
                nxt_sig[otm_sig_ch(sidx_ff)] = o[7];
              end
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      data_ff <= '0;
      stat_ff <= '0;
      ov_ff <= 1'b0;
      od_ff <= OCT_FILL;
      sig_ff <= '0;
      al_ff <= ALIGN_RST;
      far_ff <= 1'b0;
      fdone_ff <= 1'b0;
      sdone_ff <= 1'b0;
      sdiv_ff <= 4'h0;
      sidx_ff <= 5'h00;
      sync_ff <= 1'b1;
      rev_ff <= 8'h00;
      rval_ff <= 1'b0;
    end else begin
      data_ff <= nxt_data;
      stat_ff <= nxt_stat;
      ov_ff <= nxt_ov;
      od_ff <= nxt_od;
      sig_ff <= nxt_sig;
      al_ff <= nxt_al;
      far_ff <= nxt_far;
      fdone_ff <= nxt_fdone;
      sdone_ff <= nxt_sdone;
      sdiv_ff <= nxt_sdiv;
      sidx_ff <= nxt_sidx;
      sync_ff <= nxt_sync;
      rev_ff <= nxt_rev;
      rval_ff <= nxt_rval;
    end
  end

  assign rx_data_o = data_ff;
  assign rx_stat_o = stat_ff;
  assign oct_valid_o = ov_ff;
  assign oct_data_o = od_ff;
  assign sig_o = sig_ff;
  assign oof_o = al_ff.oof;
  assign far_alarm_o = far_ff;
  assign link.rev_octet = rev_ff;
  assign link.rev_valid = rval_ff;
endmodule // otm_peer

// ==== verif/otm_sva.sv ====
// checker for the forward and reverse link signals of the octet multiplexer
// assumes one clock and a synchronous active-high reset for both ends
`timescale 1ns/10ps
module otm_sva #(
  parameter int NUM_SLOTS = 8,
  parameter int SW = 3
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [7:0] fwd_octet,
  input wire logic [SW-1:0] fwd_slot,
  input wire logic fwd_sof,
  input wire logic fwd_valid,
  input wire logic fwd_used,
  input wire logic [7:0] rev_octet,
  input wire logic rev_valid
);
  import otm_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  logic [11:0] gap_ff;
  logic [11:0] nxt_gap;
  logic seen_ff;
  logic nxt_seen;
  always_comb begin
    nxt_gap = fwd_sof ? 12'h000 : gap_ff + 12'h001;
    nxt_seen = seen_ff | fwd_sof;
  end
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      gap_ff <= 12'h000;
      seen_ff <= 1'b0;
    end else begin
      gap_ff <= nxt_gap;
      seen_ff <= nxt_seen;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence s_slot_burst;
    fwd_valid [*8] ##1 !fwd_valid;
  endsequence
  sequence s_rev_reply;
    ##1 rev_valid ##1 !rev_valid;
  endsequence
  a_sof_slot_zero: assert property (fwd_sof |-> fwd_valid && fwd_slot == '0)
    else $error("frame start not on slot zero");
  a_slot_burst: assert property (fwd_sof |-> s_slot_burst)
    else $error("slot burst length wrong");
  a_slot_order: assert property (fwd_valid && !fwd_sof |->
    $past(fwd_valid) && fwd_slot == SW'($past(fwd_slot) + 1'b1))
    else $error("slots out of order");
  a_frame_period: assert property (fwd_sof && seen_ff |-> gap_ff == 12'(FRAME_CYC - 1))
    else $error("frame period wrong");
  a_rev_reply: assert property (fwd_sof |-> s_rev_reply)
    else $error("reverse octet missing");
  a_rev_cause: assert property (rev_valid |-> $past(fwd_sof))
    else $error("reverse octet without frame");
  a_rev_format: assert property (rev_valid |-> rev_octet[6:1] == 6'h00)
    else $error("reverse octet format");
  a_unused_fill: assert property (fwd_valid && !fwd_used |-> fwd_octet == OCT_FILL)
    else $error("unused slot not filled");
  a_idle_quiet: assert property (!fwd_valid |-> !fwd_sof && !fwd_used)
    else $error("link active outside slots");
endmodule // otm_sva

// ==== verif/tb.sv ====
// testbench joining the multiplexer and its peer over one link
// assumes 20 MHz clock, inputs driven on the falling edge
`timescale 1ns/10ps
module tb;
  import otm_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  localparam int CEIL = 92000;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  otm_slot_t [7:0] slot_type;
  logic [7:0][7:0] slot_data;
  logic [7:0] slot_stat = 8'h05;
  logic [7:0][7:0] voice_mask;
  logic [SIG_CH-1:0] sig = 18'h3A5C5;
  logic oct_valid = 1'b0;
  logic [7:0] oct_data = 8'h00;
  logic oct_ready;
  logic [1:0] oof;
  logic [1:0] far_alarm;
  logic [7:0][7:0] rx_data;
  logic [SIG_CH-1:0] rx_sig;
  logic [7:0] rx_stat;
  logic rx_oct_valid;
  logic [7:0] rx_oct;
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int nframe = 0;
  int n_got = 0;
  int pos;
  always #25 clock_i = ~clock_i;
  initial begin
    slot_type[0] = S_X50;
    slot_type[1] = S_E48;
    slot_type[2] = S_E56;
    slot_type[3] = S_OCT;
    slot_type[4] = S_VOICE;
    slot_type[5] = S_SIG;
    slot_type[6] = S_OCT;
    slot_type[7] = S_UNUSED;
    slot_data = 64'h11223344_5566A5D3;
    voice_mask = 64'h000000F0_00000000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  otm_link_if #(.NUM_SLOTS(8)) otm_link_if_inst ();
  otm_mux #(.NUM_SLOTS(8), .FIFO_DEPTH(8)) otm_mux_inst (
    .clock_i(clock_i), .reset_i(reset_i), .slot_type_i(slot_type), .slot_data_i(slot_data),
    .slot_stat_i(slot_stat), .voice_mask_i(voice_mask), .sig_i(sig), .oct_valid_i(oct_valid),
    .oct_data_i(oct_data), .oct_ready_o(oct_ready), .oof_o(oof[0]),
    .far_alarm_o(far_alarm[0]), .link(otm_link_if_inst.mux));
  otm_peer #(.NUM_SLOTS(8)) otm_peer_inst (
    .clock_i(clock_i), .reset_i(reset_i), .slot_type_i(slot_type), .voice_mask_i(voice_mask),
    .link(otm_link_if_inst.peer), .rx_data_o(rx_data), .rx_stat_o(rx_stat),
    .oct_valid_o(rx_oct_valid), .oct_data_o(rx_oct), .sig_o(rx_sig), .oof_o(oof[1]),
    .far_alarm_o(far_alarm[1]));
  otm_sva #(.NUM_SLOTS(8), .SW(3)) otm_sva_inst (
    .clock_i(clock_i), .reset_i(reset_i), .fwd_octet(otm_link_if_inst.fwd_octet),
    .fwd_slot(otm_link_if_inst.fwd_slot), .fwd_sof(otm_link_if_inst.fwd_sof),
    .fwd_valid(otm_link_if_inst.fwd_valid), .fwd_used(otm_link_if_inst.fwd_used),
    .rev_octet(otm_link_if_inst.rev_octet), .rev_valid(otm_link_if_inst.rev_valid));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("errors=%0d checked=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // holds valid across calls; caller drops it after the last octet
  task automatic put_oct(input logic [7:0] d);
    int k;
    k = 0;
    oct_data = d;
    oct_valid = 1'b1;
    exp_q.push_back(d);
    do begin
      @(posedge clock_i);
      k++;
    end while (oct_ready !== 1'b1 && k < 8000);
    if (oct_ready !== 1'b1) n_errors++;
    @(negedge clock_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // link outputs are looked at mid-cycle, where they have settled
  always @(negedge clock_i) begin
    cyc++;
    if (cyc == CEIL) begin
      n_errors++;
      results();
    end
    if (otm_link_if_inst.fwd_sof === 1'b1) nframe++;
    if (otm_link_if_inst.fwd_valid === 1'b1) begin
      case (otm_link_if_inst.fwd_slot)
        3'h0: chk(otm_link_if_inst.fwd_octet,
          {FA_PATTERN[(nframe - 1) % 20], slot_data[0][5:0], slot_stat[0]});
        3'h1: chk(otm_link_if_inst.fwd_octet, {E48_FILL, slot_data[1][5:0], slot_stat[1]});
        3'h2: chk(otm_link_if_inst.fwd_octet, {slot_data[2][6:0], slot_stat[2]});
        3'h4: chk(otm_link_if_inst.fwd_octet, slot_data[4] & voice_mask[4]);
        3'h5: begin
          pos = ((nframe - 1) / 10) % 20;
          chk(otm_link_if_inst.fwd_octet, {(pos == 0) ? 1'(((nframe - 1) / 200) % 2) :
            (pos == 10) ? ALARM_OFF : sig[(pos < 10) ? pos - 1 : pos - 2], 7'h00});
        end
        3'h7: chk({7'h00, otm_link_if_inst.fwd_used}, 8'h00);
        default: ;
      endcase
    end
    if (otm_link_if_inst.rev_valid === 1'b1 && nframe <= 2)
      chk({7'h00, otm_link_if_inst.rev_octet[0]}, {7'h00, ALARM_ON});
    if (otm_link_if_inst.rev_valid === 1'b1 && nframe >= 16)
      chk({7'h00, otm_link_if_inst.rev_octet[0]}, {7'h00, ALARM_OFF});
    if (rx_oct_valid === 1'b1) begin
      n_got++;
      if (exp_q.size() == 0) chk(rx_oct, 8'hXX);
      else chk(rx_oct, exp_q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge clock_i);
    reset_i = 1'b0;
    for (int k = 0; k < 20 * FRAME_CYC && oof !== 2'b00; k++) @(negedge clock_i);
    chk({6'h00, oof}, 8'h00);
    @(posedge otm_link_if_inst.fwd_sof);
    repeat (20) @(negedge clock_i);
    // the peer's first no-alarm reply lands one frame after it locks
    chk({7'h00, far_alarm[0]}, 8'h00);
    for (int i = 0; i < 10; i++) begin
      if (i == 8) chk({7'h00, oct_ready}, 8'h00);
      put_oct(8'hA0 + 8'(i));
    end
    oct_valid = 1'b0;
    repeat (7 * FRAME_CYC) @(negedge clock_i);
    chk(8'(n_got), 8'h0A);
    chk({2'b00, rx_data[1][5:0]}, {2'b00, slot_data[1][5:0]});
    chk({1'b0, rx_data[2][6:0]}, {1'b0, slot_data[2][6:0]});
    chk(rx_data[4] & voice_mask[4], slot_data[4] & voice_mask[4]);
    chk({5'h00, rx_stat[2:0]}, {5'h00, slot_stat[2:0]});
    chk({2'b00, rx_data[0][5:0]}, {2'b00, slot_data[0][5:0]});
    // new status and signalling mid-frame; bit 1 of sig is first sent in frame 21
    @(posedge otm_link_if_inst.fwd_sof);
    repeat (20) @(negedge clock_i);
    slot_stat = 8'h02;
    sig = 18'h3A5C7;
    while (nframe < 34) @(negedge clock_i);
    chk({5'h00, rx_stat[2:0]}, {5'h00, slot_stat[2:0]});
    chk({5'h00, rx_sig[2:0]}, {5'h00, sig[2:0]});
    chk({7'h00, far_alarm[1]}, 8'h00);
    results();
  end
endmodule // tb
